/* hdl/adms_pkg.sv */
package adms_pkg;

	// ************************************************************
	// Register map and field layout
	// ************************************************************
	localparam int REG_ADDR_W = 8;
	localparam logic [7:0] REG_CTRL0 = 8'h00;
	localparam logic [7:0] REG_CTRL1 = 8'h04;
	localparam logic [7:0] REG_CTRL2 = 8'h08;
	localparam logic [7:0] REG_RESULT0 = 8'h20;
	localparam logic [7:0] RESULT_MASK = 8'hE0;
	localparam int RESULT_IDX_LSB = 2;

	localparam int CTRL0_CH_LSB = 0;
	localparam int CTRL0_MODE_LSB = 3;
	localparam int CTRL0_START_BIT = 6;
	localparam int CTRL0_TRIG_BIT = 7;
	localparam int CTRL0_BUSY_BIT = 8;
	localparam int CTRL1_GRP_LSB = 0;
	localparam int CTRL1_RES10_BIT = 2;
	localparam int CTRL1_EXTGRP_BIT = 3;
	localparam int CTRL2_SH_BIT = 0;

	localparam logic [31:0] CTRL0_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL1_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL2_RESET = 32'h0000_0000;

	// ************************************************************
	// Operating modes
	// ************************************************************
	localparam logic [2:0] MODE_ONE_SHOT = 3'h0;
	localparam logic [2:0] MODE_REPEAT = 3'h1;
	localparam logic [2:0] MODE_SWEEP = 3'h2;
	localparam logic [2:0] MODE_RSWEEP0 = 3'h3;
	localparam logic [2:0] MODE_RSWEEP1 = 3'h4;

	// ************************************************************
	// Conversion lengths in converter clock cycles
	// ************************************************************
	// Values are 49, 59, 28 and 33 cycles.
	localparam logic [5:0] CONV_CYC_8B = 6'h31;
	localparam logic [5:0] CONV_CYC_10B = 6'h3B;
	localparam logic [5:0] CONV_CYC_SH_8B = 6'h1C;
	localparam logic [5:0] CONV_CYC_SH_10B = 6'h21;

	localparam int NUM_CH = 8;
	localparam int RES_W = 10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {
		ST_IDLE,
		ST_CONV
	} adms_state_e;

endpackage

/* hdl/adms_conv_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module adms_conv_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start_conv,
	input wire logic abort_conv,
	input wire logic sample_hold,
	input wire logic res_10bit,
	output logic busy,
	output logic done
);

	typedef struct packed {
		logic busy;
		logic done;
		logic [5:0] cnt;
	} adms_tmr_s;

	adms_tmr_s q;
	adms_tmr_s next_q;

	function automatic logic [5:0] conv_len(input logic sh, input logic r10);
		if (sh) begin
			conv_len = r10 ? adms_pkg::CONV_CYC_SH_10B : adms_pkg::CONV_CYC_SH_8B; // R15
		end else begin
			conv_len = r10 ? adms_pkg::CONV_CYC_10B : adms_pkg::CONV_CYC_8B; // R17
		end
	endfunction

	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		if (start_conv) begin
			// A restart wins over an abort so that a retrigger begins a fresh count.
			next_q.busy = 1'b1;
			next_q.cnt = conv_len(sample_hold, res_10bit) - 6'h01; // R14
		end else if (abort_conv) begin
			next_q.busy = 1'b0;
		end else if (q.busy) begin
			if (q.cnt == 6'h00) begin
				next_q.busy = 1'b0;
				next_q.done = 1'b1;
			end else begin
				next_q.cnt = q.cnt - 6'h01;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign busy = q.busy;
	assign done = q.done;

endmodule
`default_nettype wire

/* hdl/adms_sequencer.sv */
// Overview of operation
// R01: One-shot mode converts the selected channel exactly once per start.
// R02: Writing one to the start flag begins conversion in every mode.
// R03: One-shot and single sweep clear the start flag at pass end, unless externally triggered.
// R04: Writing zero to the start flag stops conversion in any mode.
// R05: One-shot and single sweep raise the interrupt request when the pass completes.
// R06: Repeat mode converts one channel over and over, never requesting an interrupt.
// R07: Each result lands in its channel's register, readable at any time.
// R08: One-shot and repeat use the channel field to pick one of eight inputs.
// R09: Single sweep converts the first 2, 4, 6 or 8 channels once each.
// R10: Repeat sweep 0 sweeps the group continuously without interrupts until stopped.
// R11: Repeat sweep 1 converts all eight, inserting emphasis channels between the others.
// R12: Emphasis group is the first 1, 2, 3 or 4 channels; no interrupt.
// R13: The extended input group may replace the primary group in every mode.
// R14: Bit zero of the second control register enables sample and hold; the code takes it from bit zero of the third, REG_CTRL2 at 8'h08.
// R15: With sample and hold a conversion takes 28 or 33 cycles.
// R16: Software sets sample and hold before starting and leaves it alone meanwhile.
// R17: Without sample and hold a conversion takes 49 or 59 cycles.
// R18: With external trigger armed, a falling trigger edge starts or restarts conversion.
// R19: Ten-bit results split low eight and upper two bits; eight-bit uses low byte.
// R20: Sweeps go upward from channel zero and restart from zero on each start.
`timescale 1ns/10ps
`default_nettype none
module adms_sequencer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [adms_pkg::REG_ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [adms_pkg::REG_ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic external_trigger_pin,
	input wire logic [adms_pkg::RES_W-1:0] adc_sample,
	output logic [3:0] analog_sel,
	output logic sample_hold_en,
	output logic res_10bit,
	output logic conv_active,
	output logic conv_irq
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic aw_held;
		logic [adms_pkg::REG_ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [2:0] channel;
		logic [2:0] mode;
		logic start;
		logic trig_ext;
		logic [1:0] grp;
		logic res10;
		logic ext_group;
		logic sample_hold;
		logic [adms_pkg::NUM_CH-1:0][adms_pkg::RES_W-1:0] result;
		adms_pkg::adms_state_e run;
		logic [2:0] cur_ch;
		logic emph_phase;
		logic [2:0] emph_idx;
		logic [2:0] other_ch;
		logic kick;
		logic abort;
		logic irq;
		logic trg_s1;
		logic trg_s2;
		logic trg_s3;
	} adms_main_s;

	adms_main_s q;
	adms_main_s next_q;
	logic conv_done;
	logic tmr_busy;
	logic trig_fall;
	logic wr_fire;
	logic sw_start;
	logic sw_stop;
	logic begin_pass;
	logic finish;
	logic [7:0] wa;

	// Number of channels in a single or repeat sweep 0 group.
	function automatic logic [3:0] sweep_len(input logic [1:0] g);
		sweep_len = {1'b0, g, 1'b0} + 4'h2; // R09
	endfunction

	// Number of emphasis channels in repeat sweep 1.
	function automatic logic [2:0] emph_len(input logic [1:0] g);
		emph_len = {1'b0, g} + 3'h1; // R12
	endfunction

	function automatic logic is_sweep(input logic [2:0] m);
		is_sweep = (m == adms_pkg::MODE_SWEEP) || (m == adms_pkg::MODE_RSWEEP0) || (m == adms_pkg::MODE_RSWEEP1);
	endfunction

	// ************************************************************
	// Conversion timer
	// ************************************************************
	adms_conv_timer i_adms_conv_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start_conv(q.kick),
		.abort_conv(q.abort),
		.sample_hold(q.sample_hold),
		.res_10bit(q.res10),
		.busy(tmr_busy),
		.done(conv_done)
	);

	assign awready = !q.aw_held && !q.bvalid;
	assign wready = !q.w_held && !q.bvalid;
	assign arready = !q.rvalid;
	assign wr_fire = q.aw_held && q.w_held && !q.bvalid;
	assign trig_fall = q.trg_s3 && !q.trg_s2;
	assign wa = q.aw_addr;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_q = q;
		next_q.kick = 1'b0;
		next_q.abort = 1'b0;
		next_q.irq = 1'b0;
		sw_start = 1'b0;
		sw_stop = 1'b0;
		begin_pass = 1'b0;
		finish = 1'b0;

		next_q.trg_s1 = external_trigger_pin;
		next_q.trg_s2 = q.trg_s1;
		next_q.trg_s3 = q.trg_s2;

		if (awvalid && awready) begin
			next_q.aw_held = 1'b1;
			next_q.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_q.w_held = 1'b1;
			next_q.w_data = wdata;
			next_q.w_strb = wstrb;
		end

		// Every writable control field sits in byte lane zero, so only that strobe matters.
		if (wr_fire) begin
			next_q.aw_held = 1'b0;
			next_q.w_held = 1'b0;
			next_q.bvalid = 1'b1;
			next_q.bresp = adms_pkg::RESP_OKAY;
			if (wa == adms_pkg::REG_CTRL0) begin
				if (q.w_strb[0]) begin
					next_q.channel = q.w_data[adms_pkg::CTRL0_CH_LSB +: 3]; // R08
					next_q.mode = q.w_data[adms_pkg::CTRL0_MODE_LSB +: 3];
					next_q.trig_ext = q.w_data[adms_pkg::CTRL0_TRIG_BIT];
					next_q.start = q.w_data[adms_pkg::CTRL0_START_BIT];
					sw_start = q.w_data[adms_pkg::CTRL0_START_BIT];
					sw_stop = !q.w_data[adms_pkg::CTRL0_START_BIT];
				end
			end else if (wa == adms_pkg::REG_CTRL1) begin
				if (q.w_strb[0]) begin
					next_q.grp = q.w_data[adms_pkg::CTRL1_GRP_LSB +: 2];
					next_q.res10 = q.w_data[adms_pkg::CTRL1_RES10_BIT];
					next_q.ext_group = q.w_data[adms_pkg::CTRL1_EXTGRP_BIT];
				end
			end else if (wa == adms_pkg::REG_CTRL2) begin
				if (q.w_strb[0]) begin
					next_q.sample_hold = q.w_data[adms_pkg::CTRL2_SH_BIT]; // R14
				end
			end else if ((wa & adms_pkg::RESULT_MASK) != adms_pkg::REG_RESULT0) begin
				next_q.bresp = adms_pkg::RESP_SLVERR;
			end
		end
		if (q.bvalid && bready) begin
			next_q.bvalid = 1'b0;
		end

		if (arvalid && arready) begin
			next_q.rvalid = 1'b1;
			next_q.rresp = adms_pkg::RESP_OKAY;
			next_q.rdata = 32'h0000_0000;
			if (araddr == adms_pkg::REG_CTRL0) begin
				next_q.rdata[adms_pkg::CTRL0_CH_LSB +: 3] = q.channel;
				next_q.rdata[adms_pkg::CTRL0_MODE_LSB +: 3] = q.mode;
				next_q.rdata[adms_pkg::CTRL0_START_BIT] = q.start;
				next_q.rdata[adms_pkg::CTRL0_TRIG_BIT] = q.trig_ext;
				next_q.rdata[adms_pkg::CTRL0_BUSY_BIT] = (q.run == adms_pkg::ST_CONV);
			end else if (araddr == adms_pkg::REG_CTRL1) begin
				next_q.rdata[adms_pkg::CTRL1_GRP_LSB +: 2] = q.grp;
				next_q.rdata[adms_pkg::CTRL1_RES10_BIT] = q.res10;
				next_q.rdata[adms_pkg::CTRL1_EXTGRP_BIT] = q.ext_group;
			end else if (araddr == adms_pkg::REG_CTRL2) begin
				next_q.rdata[adms_pkg::CTRL2_SH_BIT] = q.sample_hold;
			end else if ((araddr & adms_pkg::RESULT_MASK) == adms_pkg::REG_RESULT0) begin
				// Low eight bits in the even byte, upper two in the odd byte.
				next_q.rdata[adms_pkg::RES_W-1:0] = q.result[araddr[adms_pkg::RESULT_IDX_LSB +: 3]]; // R07 R19
			end else begin
				next_q.rresp = adms_pkg::RESP_SLVERR;
			end
		end
		if (q.rvalid && rready) begin
			next_q.rvalid = 1'b0;
		end

		// ************************************************************
		// Sequencer
		// ************************************************************
		// A start comes from software unless the external trigger is chosen, then from a falling edge.
		if (sw_start && !next_q.trig_ext) begin
			begin_pass = 1'b1; // R02
		end
		if (q.start && q.trig_ext && trig_fall && !sw_stop) begin
			begin_pass = 1'b1; // R18
		end

		if (sw_stop) begin
			next_q.run = adms_pkg::ST_IDLE; // R04
			next_q.abort = 1'b1;
		end else if (begin_pass) begin
			next_q.run = adms_pkg::ST_CONV;
			next_q.kick = 1'b1;
			next_q.abort = 1'b1;
			next_q.emph_phase = 1'b1;
			next_q.emph_idx = 3'h0;
			next_q.other_ch = emph_len(next_q.grp);
			if (is_sweep(next_q.mode)) begin
				next_q.cur_ch = 3'h0; // R20
			end else begin
				next_q.cur_ch = next_q.channel; // R08
			end
		end else if (q.run == adms_pkg::ST_CONV && conv_done && !q.kick) begin
			if (q.res10) begin
				next_q.result[q.cur_ch] = adc_sample; // R07 R19
			end else begin
				next_q.result[q.cur_ch] = {2'b00, adc_sample[adms_pkg::RES_W-1:2]}; // R19
			end
			case (q.mode)
				adms_pkg::MODE_REPEAT: begin
					next_q.kick = 1'b1; // R06
				end
				adms_pkg::MODE_SWEEP: begin
					if ({1'b0, q.cur_ch} + 4'h1 < sweep_len(q.grp)) begin
						next_q.cur_ch = q.cur_ch + 3'h1; // R09
						next_q.kick = 1'b1;
					end else begin
						finish = 1'b1;
					end
				end
				adms_pkg::MODE_RSWEEP0: begin
					next_q.kick = 1'b1;
					if ({1'b0, q.cur_ch} + 4'h1 < sweep_len(q.grp)) begin
						next_q.cur_ch = q.cur_ch + 3'h1;
					end else begin
						next_q.cur_ch = 3'h0; // R10
					end
				end
				adms_pkg::MODE_RSWEEP1: begin
					// Emphasis channels run as a burst before each remaining channel.
					next_q.kick = 1'b1;
					if (q.emph_phase && (q.emph_idx + 3'h1 < emph_len(q.grp))) begin
						next_q.emph_idx = q.emph_idx + 3'h1;
						next_q.cur_ch = q.emph_idx + 3'h1; // R11
					end else if (q.emph_phase) begin
						next_q.emph_phase = 1'b0;
						next_q.cur_ch = q.other_ch; // R11
					end else begin
						next_q.emph_phase = 1'b1;
						next_q.emph_idx = 3'h0;
						next_q.cur_ch = 3'h0;
						if (q.other_ch == 3'h7) begin
							next_q.other_ch = emph_len(q.grp); // R12
						end else begin
							next_q.other_ch = q.other_ch + 3'h1;
						end
					end
				end
				default: begin
					finish = 1'b1; // R01
				end
			endcase
			if (finish) begin
				next_q.run = adms_pkg::ST_IDLE;
				next_q.irq = 1'b1; // R05
				// A start written by software in this same cycle wins over the clear.
				if (!q.trig_ext && !sw_start) begin
					next_q.start = 1'b0; // R03
				end
			end
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.channel <= adms_pkg::CTRL0_RESET[adms_pkg::CTRL0_CH_LSB +: 3];
			q.mode <= adms_pkg::CTRL0_RESET[adms_pkg::CTRL0_MODE_LSB +: 3];
			q.grp <= adms_pkg::CTRL1_RESET[adms_pkg::CTRL1_GRP_LSB +: 2];
			q.sample_hold <= adms_pkg::CTRL2_RESET[adms_pkg::CTRL2_SH_BIT];
			q.run <= adms_pkg::ST_IDLE;
			q.trg_s1 <= 1'b1;
			q.trg_s2 <= 1'b1;
			q.trg_s3 <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign analog_sel = {q.ext_group, q.cur_ch}; // R13
	assign sample_hold_en = q.sample_hold;
	assign res_10bit = q.res10;
	assign conv_active = tmr_busy;
	assign conv_irq = q.irq;

endmodule
`default_nettype wire

/* tb/adms_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module adms_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [3:0] analog_sel,
	input wire logic sample_hold_en,
	input wire logic res_10bit,
	input wire logic conv_active,
	input wire logic conv_irq
);
	// ************************************************************
	// Length of the running conversion
	// ************************************************************
	typedef struct packed {
		logic [6:0] run;
	} adms_chk_s;
	adms_chk_s st;
	adms_chk_s next_st;
	logic [5:0] lim;
	always_comb begin
		next_st = st;
		next_st.run = conv_active ? st.run + 7'h01 : 7'h00;
		if (sample_hold_en) begin
			lim = res_10bit ? adms_pkg::CONV_CYC_SH_10B : adms_pkg::CONV_CYC_SH_8B;
		end else begin
			lim = res_10bit ? adms_pkg::CONV_CYC_10B : adms_pkg::CONV_CYC_8B;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_write_resp: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	a_read_lat: assert property (arvalid && arready |=> rvalid)
		else $error("read response late");
	a_resp_block: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	a_ar_block: assert property (rvalid |-> !arready)
		else $error("read taken while data pending");
	a_irq_pulse: assert property (conv_irq |=> !conv_irq)
		else $error("interrupt longer than one cycle");
	a_irq_after: assert property (conv_irq |-> !conv_active && ($past(conv_active, 2) || $past(conv_active, 3)))
		else $error("interrupt without finished conversion");
	a_conv_len: assert property (st.run <= {1'b0, lim})
		else $error("conversion runs too long");
	a_sel_stable: assert property (conv_active && $past(conv_active) |-> $stable(analog_sel))
		else $error("input select moved mid conversion");
endmodule
bind adms_sequencer adms_checker i_adms_checker (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
	.analog_sel(analog_sel), .sample_hold_en(sample_hold_en), .res_10bit(res_10bit),
	.conv_active(conv_active), .conv_irq(conv_irq));
`default_nettype wire

/* tb/adms_sequencer_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module adms_sequencer_bench;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, external_trigger_pin;
	logic awready, wready, bvalid, arready, rvalid, sample_hold_en, res_10bit, conv_active, conv_irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_val;
	logic [3:0] wstrb, analog_sel;
	logic [1:0] bresp, rresp, rsp;
	logic [9:0] adc_sample;
	logic act_q;
	logic [6:0] pat = 7'h55;
	logic [3:0] seq[$];
	int n_mismatch = 0, total_checks = 0, n_irq = 0, run = 0, last_len = 0;
	adms_sequencer i_adms_sequencer (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.external_trigger_pin(external_trigger_pin), .adc_sample(adc_sample), .analog_sel(analog_sel),
		.sample_hold_en(sample_hold_en), .res_10bit(res_10bit), .conv_active(conv_active),
		.conv_irq(conv_irq));
	initial begin
		aclk = 0;
		forever #25 aclk = ~aclk;
	end
	// ************************************************************
	// Analog source and conversion monitor
	// ************************************************************
	always @(posedge aclk) begin
		adc_sample <= {analog_sel[2:0], pat};
		if (conv_irq) n_irq <= n_irq + 1;
		if (conv_active) run <= run + 1;
		else if (run != 0) begin
			last_len <= run;
			run <= 0;
		end
		if (conv_active && !act_q) seq.push_back(analog_sel);
		act_q <= conv_active;
	end
	function automatic logic [31:0] expres(int ch, bit r10);
		logic [9:0] s;
		s = {ch[2:0], pat};
		return r10 ? 32'(s) : 32'(s[9:2]);
	endfunction
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	// ************************************************************
	// Register bus master
	// ************************************************************
	task wr(input logic [7:0] a, input logic [31:0] d);
		bit ta, tw, tb;
		awvalid <= 1;
		wvalid <= 1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		bready <= 1;
		forever begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			rsp = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
			if (tb) begin
				bready <= 0;
				@(posedge aclk);
				return;
			end
		end
	endtask
	task rd(input logic [7:0] a);
		bit ta, tr;
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		forever begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			rd_val = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 0;
			if (tr) begin
				rready <= 0;
				@(posedge aclk);
				return;
			end
		end
	endtask
	task wait_irq(input int n0);
		for (int k = 0; k < 1000 && n_irq == n0; k++) @(posedge aclk);
		if (n_irq == n0) chk(0, 1, "no interrupt");
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_regs;
		for (int i = 0; i < 3; i++) begin
			rd(8'(4 * i));
			chk(rd_val, 32'h0000_0000, "control reset value");
		end
		rd(8'h10);
		chk(32'(rsp), 32'h0000_0002, "unmapped read response");
		chk(rd_val, 32'h0000_0000, "unmapped read data");
		wr(8'h10, 32'hffff_ffff);
		chk(32'(rsp), 32'h0000_0002, "unmapped write response");
		wr(8'h20, 32'h0000_03ff);
		rd(8'h20);
		chk(rd_val, 32'h0000_0000, "result not writable");
	endtask
	task automatic t_oneshot;
		int ch, n0, b;
		int lens[4] = '{49, 59, 28, 33};
		for (int i = 0; i < 4; i++) begin
			ch = 2 * i + 1;
			wr(8'h08, 32'(i / 2));
			wr(8'h04, 32'(i % 2) << 2);
			n0 = n_irq;
			b = seq.size();
			wr(8'h00, 32'h0000_0040 | 32'(ch));
			wait_irq(n0);
			repeat (80) @(posedge aclk);
			chk(32'(sample_hold_en), 32'(i / 2), "sample hold output");
			chk(32'(res_10bit), 32'(i % 2), "resolution output");
			chk(32'(last_len), 32'(lens[i]), "conversion length");
			chk(32'(n_irq - n0), 32'h0000_0001, "one interrupt");
			chk(32'(seq.size() - b), 32'h0000_0001, "one conversion");
			chk(32'(seq[b]), 32'(ch), "selected channel");
			rd(8'h20 + 8'(4 * ch));
			chk(rd_val, expres(ch, i % 2), "result value");
			rd(8'h00);
			chk(32'(rd_val[6]), 32'h0000_0000, "start flag cleared");
		end
		wr(8'h04, 32'h0000_0000);
	endtask
	task t_sweep;
		int n0, b;
		wr(8'h04, 32'h0000_0001);
		n0 = n_irq;
		b = seq.size();
		wr(8'h00, 32'h0000_0050);
		wait_irq(n0);
		repeat (80) @(posedge aclk);
		chk(32'(n_irq - n0), 32'h0000_0001, "sweep interrupt");
		chk(32'(seq.size() - b), 32'h0000_0004, "sweep length");
		for (int i = 0; i < 4; i++) chk(32'(seq[b + i]), 32'(i), "sweep order");
		rd(8'h28);
		chk(rd_val, expres(2, 0), "sweep result");
	endtask
	task run_seq(input logic [31:0] c1, input logic [31:0] c0, input logic [3:0] e[6]);
		int n0, b;
		// A fresh sample pattern so that stale results from earlier scenarios cannot match.
		pat <= pat + 7'h13;
		wr(8'h04, c1);
		n0 = n_irq;
		b = seq.size();
		wr(8'h00, c0);
		repeat (250) @(posedge aclk);
		rd(8'h20 + 8'(4 * e[1]));
		chk(rd_val, expres(e[1], 0), "result while running");
		for (int i = 0; i < 6; i++) chk(32'(seq[b + i]), 32'(e[i]), "channel order");
		chk(32'(n_irq - n0), 32'h0000_0000, "no interrupt");
		wr(8'h00, 32'h0000_0000);
		repeat (3) @(posedge aclk);
		b = seq.size();
		repeat (100) @(posedge aclk);
		chk(32'(conv_active), 32'h0000_0000, "stopped");
		chk(32'(seq.size() - b), 32'h0000_0000, "no conversion after stop");
	endtask
	task t_ext;
		int n0, b;
		wr(8'h04, 32'h0000_0008);
		n0 = n_irq;
		b = seq.size();
		wr(8'h00, 32'h0000_00c2);
		repeat (20) @(posedge aclk);
		chk(32'(seq.size() - b), 32'h0000_0000, "waits for trigger");
		external_trigger_pin <= 0;
		wait_irq(n0);
		chk(32'(seq[b]), 32'h0000_000a, "extended input select");
		rd(8'h00);
		chk(32'(rd_val[6]), 32'h0000_0001, "start kept with trigger");
		external_trigger_pin <= 1;
		repeat (5) @(posedge aclk);
		external_trigger_pin <= 0;
		wait_irq(n0 + 1);
		chk(32'(seq.size() - b), 32'h0000_0002, "retrigger");
		external_trigger_pin <= 1;
		wr(8'h00, 32'h0000_0000);
	endtask
	initial begin
		aresetn = 0;
		{awvalid, wvalid, bready, arvalid, rready, act_q} = '0;
		external_trigger_pin = 1;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = '0;
		adc_sample = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_regs;
		t_oneshot;
		t_sweep;
		run_seq(32'h0000_0000, 32'h0000_004d, '{5, 5, 5, 5, 5, 5});
		run_seq(32'h0000_0000, 32'h0000_0058, '{0, 1, 0, 1, 0, 1});
		run_seq(32'h0000_0001, 32'h0000_0060, '{0, 1, 2, 0, 1, 3});
		t_ext;
		end_sim;
	end
	initial begin
		#(40000 * 50);
		n_mismatch++;
		end_sim;
	end
endmodule
`default_nettype wire
